// ### bench/pgr_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module pgr_core_tb;
   localparam logic [15:0] MAKER = 16'h1234;  // arbitrary value
   localparam logic [15:0] REV   = 16'h4B2E;  // arbitrary value
   logic        clk_i, nrst_i, bus_reset, rx_valid, tx_ready, tx_valid;
   logic        entropy_ok, key_puf, cnt_mode, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  rx_byte, tx_byte;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic [7:0]  q[$];
   int          mismatches, checks;
   logic [7:0]  prm_t[4] = '{8'h00, 8'h01, 8'h01, 8'h02};
   logic        ok_t[4]  = '{1'b1, 1'b1, 1'b0, 1'b1};
   logic [7:0]  res_t[4] = '{8'hAA, 8'hAA, 8'hAA, 8'h77};
   logic [7:0]  hlt_t[4] = '{8'hFF, 8'hAA, 8'hDD, 8'hFF};
   pgr_core #(.READ_DELAY_CYC(4), .HEALTH_DELAY_CYC(8), .MAKER_CODE_RST(MAKER),
      .REVISION(REV)) u_pgr_core (.clk_i(clk_i), .nrst_i(nrst_i), .bus_reset_i(bus_reset),
      .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .tx_ready_i(tx_ready),
      .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .entropy_ok_i(entropy_ok),
      .key_source_puf_o(key_puf), .counter_mode_o(cnt_mode), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   pgr_host u_pgr_host (.clk_i(clk_i), .bus_reset_o(bus_reset), .rx_valid_o(rx_valid),
      .rx_byte_o(rx_byte), .tx_ready_o(tx_ready), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte));
   always #2.5 clk_i = ~clk_i;
   task automatic stop_test();
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         mismatches++;
         stop_test();
      end
      @(posedge clk_i);
   endtask : av
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      av(1'b1, a, d, x);
   endtask : wr
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] x;
      av(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask : rd_chk
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      return c;
   endfunction : crc
   task automatic get(input logic [7:0] e, input int s);
      logic [7:0] b;
      bit         ok;
      u_pgr_host.take(s, b, ok);
      if (!ok) begin
         mismatches++;
         stop_test();
      end
      `CHK(b, e)
   endtask : get
   task automatic cmd(input logic [7:0] op, input logic [7:0] prm);
      logic [15:0] c;
      logic [7:0]  req[4];
      c = 16'h0;
      req = '{8'h66, 8'h02, op, prm};
      u_pgr_host.frame_reset();
      for (int i = 0; i < 4; i++) begin
         u_pgr_host.send(req[i]);
         c = crc(c, req[i]);
      end
      get(~c[7:0], 0);
      get(~c[15:8], 1);
      u_pgr_host.send(8'hAA);
      get(8'hFF, 0);
      c = 16'h0;
      foreach (q[i]) begin
         get(q[i], i % 3);
         c = crc(c, q[i]);
      end
      get(~c[7:0], 2);
      get(~c[15:8], 0);
      u_pgr_host.frame_reset();
   endtask : cmd
   initial begin
      #400000;
      mismatches++;
      stop_test();
   end
   initial begin
      {clk_i, nrst_i, avs_read, avs_write, mismatches, checks} = '0;
      {avs_address, avs_writedata} = '0;
      entropy_ok = 1'b1;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      `CHK({tx_valid, key_puf, cnt_mode}, 3'h2)
      rd_chk(6'h38, 32'h11);
      rd_chk(6'h20, 32'h0);
      rd_chk(6'h10, 32'h0);
      rd_chk(6'h04, {16'h0, MAKER});
      wr(6'h08, 32'h0);
      q = {8'h21, 8'hAA};
      for (int i = 0; i < 32; i++) begin
         wr(6'h0C, 32'(8'(i * 7 + 3)));
         q.push_back(8'(i * 7 + 3));
      end
      cmd(8'h44, 8'h00);
      wr(6'h08, 32'h40);
      wr(6'h0C, 32'hF0);
      wr(6'h24, 32'h03);
      wr(6'h28, 32'h04);
      wr(6'h2C, 32'h08);
      wr(6'h38, 32'h00);
      repeat (2) @(posedge clk_i);
      `CHK({key_puf, cnt_mode}, 2'h1)
      rd_chk(6'h38, 32'h01);
      // one-way page keeps only bits set in both writes
      wr(6'h08, 32'h40);
      wr(6'h0C, 32'h3C);
      wr(6'h08, 32'h40);
      rd_chk(6'h0C, 32'h30);
      wr(6'h08, 32'h20);
      wr(6'h0C, 32'h5A);
      av(1'b0, 6'h14, 32'h0, r);
      `CHK(r[0], 1'b1)
      q = {8'h21, 8'h55};
      repeat (32) q.push_back(8'hFF);
      cmd(8'h44, 8'h01);
      for (int k = 0; k < 4; k++) begin
         entropy_ok <= ok_t[k];
         q = {8'h0D, res_t[k], 8'h00, 8'h03, 8'h04, 8'h08, 8'h00, 8'h00, 8'h01,
              MAKER[7:0], MAKER[15:8], REV[7:0], REV[15:8], hlt_t[k]};
         cmd(8'hAA, prm_t[k]);
      end
      q = {8'h01, 8'h77};
      cmd(8'h44, 8'h07);
      // counter page: write and read locks do not apply
      wr(6'h2C, 32'h0B);
      wr(6'h08, 32'h60);
      q = {8'h21, 8'hAA};
      for (int i = 0; i < 32; i++) begin
         wr(6'h0C, 32'(8'(i + 1)));
         q.push_back(8'(i + 1));
      end
      cmd(8'h44, 8'h03);
      wr(6'h00, 32'h1);
      q = {8'h01, 8'h88};
      cmd(8'hAA, 8'h00);
      stop_test();
   end
endmodule : pgr_core_tb
`default_nettype wire

// ### bench/pgr_host.sv
`timescale 1ns/100ps
`default_nettype none
module pgr_host (
   input  wire logic       clk_i,
   output logic            bus_reset_o,
   output logic            rx_valid_o,
   output logic [7:0]      rx_byte_o,
   output logic            tx_ready_o,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_byte_i
);
   initial begin
      bus_reset_o = 1'b0;
      rx_valid_o  = 1'b0;
      rx_byte_o   = 8'h00;
      tx_ready_o  = 1'b0;
   end
   task automatic frame_reset();
      @(posedge clk_i);
      bus_reset_o <= 1'b1;
      @(posedge clk_i);
      bus_reset_o <= 1'b0;
   endtask : frame_reset
   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= b;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      // stale byte inverted so a late sample never matches
      rx_byte_o  <= ~b;
   endtask : send
   // polls for the answer, which covers either processing delay
   task automatic take(input int stall, output logic [7:0] b, output bit ok);
      int n;
      n = 0;
      repeat (stall + 1) @(posedge clk_i);
      tx_ready_o <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (tx_valid_i !== 1'b1 && n < 300);
      b = tx_byte_i;
      ok = (tx_valid_i === 1'b1);
      tx_ready_o <= 1'b0;
   endtask : take
endmodule : pgr_host
`default_nettype wire

// ### src/pgr_core.sv
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "pgr_defs.svh"

module pgr_core #(
   parameter int          READ_DELAY_CYC   = `PGR_READ_DELAY_CYC,
   parameter int          HEALTH_DELAY_CYC = `PGR_HEALTH_DELAY_CYC,
   parameter logic [15:0] MAKER_CODE_RST   = 16'h5A3C,  // arbitrary value
   parameter logic [15:0] REVISION         = 16'h0C07   // arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // byte link from the bit layer
   input  wire logic        bus_reset_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic [7:0]       tx_byte_o,
   // entropy source verdict
   input  wire logic        entropy_ok_i,
   // key and counter configuration to the rest of the device
   output logic             key_source_puf_o,
   output logic             counter_mode_o,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   // the wait counter is 16 bits wide
   if (READ_DELAY_CYC < 1 || HEALTH_DELAY_CYC < 1 ||
       READ_DELAY_CYC + HEALTH_DELAY_CYC > 65535) begin : g_bad_delay
      $error("pgr_core: delay counts out of range");
   end

   pgr_pkg::pgr_state_t state_q;
   logic [15:0] crc_q;
   logic [15:0] cnt_q;
   logic [5:0]  idx_q;
   logic [5:0]  len_q;
   logic [7:0]  opc_q;
   logic [7:0]  param_q;
   logic [7:0]  result_q;
   logic [7:0]  health_q;
   logic        ht_req_q;
   logic        tx_valid_q;
   logic [7:0]  tx_byte_q;

   logic [7:0]  mem_q [0:223];
   logic [4:0]  prot_q [0:6];
   logic        disabled_q;
   logic [15:0] maker_q;
   logic [7:0]  maddr_q;
   logic        wrefused_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        key_src_q;
   logic        cnt_mode_q;

   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `PGR_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc16_byte

   // reported protection: key page always read-locked
   function automatic logic [7:0] prot_rep(input logic [2:0] p, input logic [4:0] v);
      logic [7:0] r;
      r = {3'h0, v};
      if (p == `PGR_KEY_PAGE) begin
         r[`PGR_BIT_RLOCK] = 1'b1;
      end
      return r;
   endfunction : prot_rep

   // ---------------- link side ----------------
   logic        rx_take;
   logic        tx_take;
   logic [15:0] crc_rx;
   logic [15:0] crc_tx;
   logic [2:0]  rd_page;
   logic        rd_locked;
   logic [7:0]  rx_rep;
   logic [5:0]  nidx;
   logic [5:0]  k;
   logic [7:0]  next_byte;
   logic [7:0]  res_d;
   logic [5:0]  len_d;
   logic        ht_d;

   assign rx_take = rx_valid_i;
   assign tx_take = tx_valid_q & tx_ready_i;
   assign crc_rx  = crc16_byte(crc_q, rx_byte_i);
   assign crc_tx  = (idx_q >= 6'h01 && idx_q <= len_q + 6'h01) ?
                    crc16_byte(crc_q, tx_byte_q) : crc_q;
   assign rd_page = param_q[2:0];
   assign rx_rep  = (rx_byte_i[2:0] == `PGR_PAGES) ? 8'h00 :
                    prot_rep(rx_byte_i[2:0], prot_q[rx_byte_i[2:0]]);
   // judged on the parameter byte; counter page ignores its read-lock bit in counter mode
   assign rd_locked = (rx_byte_i[2:0] == `PGR_CNT_PAGE && prot_q[3][`PGR_BIT_CNT]) ? 1'b0 :
                      rx_rep[`PGR_BIT_RLOCK];

   // result, length and test request decided on the parameter byte
   always_comb begin
      res_d = `PGR_RES_OK;
      len_d = `PGR_LEN_ERR;
      ht_d  = 1'b0;
      if (opc_q == `PGR_OPC_STATUS) begin
         len_d = `PGR_LEN_STATUS;
         if (disabled_q) begin
            res_d = `PGR_RES_DISABLE;
            len_d = `PGR_LEN_ERR;
         end else if (len_q != `PGR_LEN_REQ || rx_byte_i[7:1] != 7'h00) begin
            res_d = `PGR_RES_BADPARM;
         end else begin
            ht_d = rx_byte_i[0];
         end
      end else if (opc_q == `PGR_OPC_READ) begin
         if (disabled_q) begin
            res_d = `PGR_RES_DISABLE;
         end else if (len_q != `PGR_LEN_REQ || rx_byte_i[7:3] != 5'h00 ||
                      rx_byte_i[2:0] == `PGR_PAGES) begin
            res_d = `PGR_RES_BADPARM;
         end else begin
            len_d = `PGR_LEN_READ;
            res_d = `PGR_RES_OK;
         end
      end else begin
         res_d = `PGR_RES_BADPARM;
      end
   end

   // next answer byte after the one now on the link
   always_comb begin
      nidx      = idx_q + 6'h01;
      k         = nidx - 6'h03;
      next_byte = 8'h00;
      if (nidx == len_q + 6'h02) begin
         next_byte = ~crc_tx[7:0];
      end else if (nidx == len_q + 6'h03) begin
         next_byte = ~crc_q[15:8];
      end else if (nidx == 6'h01) begin
         next_byte = {2'h0, len_q};
      end else if (nidx == 6'h02) begin
         next_byte = result_q;
      end else if (opc_q == `PGR_OPC_READ) begin
         next_byte = (result_q == `PGR_RES_LOCKED) ? `PGR_FILL_BYTE :
                     mem_q[{rd_page, k[4:0]}];
      end else begin
         case (k)
            6'h07:   next_byte = maker_q[7:0];
            6'h08:   next_byte = maker_q[15:8];
            6'h09:   next_byte = REVISION[7:0];
            6'h0A:   next_byte = REVISION[15:8];
            6'h0B:   next_byte = health_q;
            default: next_byte = (k < `PGR_PROT_BYTES) ?
                                 prot_rep(k[2:0], prot_q[k[2:0]]) : 8'h00;
         endcase
      end
   end

   // bus reset returns to idle from anywhere; the host owns framing
   always_ff @(posedge clk_i) begin
      if (!nrst_i || bus_reset_i) begin
         state_q    <= pgr_pkg::S_IDLE;
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h00;
         crc_q      <= 16'h0000;
         cnt_q      <= 16'h0000;
         idx_q      <= 6'h00;
         len_q      <= 6'h00;
         opc_q      <= 8'h00;
         param_q    <= 8'h00;
         result_q   <= 8'h00;
         health_q   <= `PGR_HT_NONE;
         ht_req_q   <= 1'b0;
      end else begin
         case (state_q)
            pgr_pkg::S_IDLE: begin
               if (rx_take && rx_byte_i == `PGR_CMD_START) begin
                  crc_q   <= crc16_byte(16'h0000, rx_byte_i);
                  state_q <= pgr_pkg::S_LEN;
               end
            end
            pgr_pkg::S_LEN: begin
               if (rx_take) begin
                  len_q   <= rx_byte_i[5:0] | {5'h00, |rx_byte_i[7:6]};
                  crc_q   <= crc_rx;
                  state_q <= pgr_pkg::S_OPC;
               end
            end
            pgr_pkg::S_OPC: begin
               if (rx_take) begin
                  opc_q   <= rx_byte_i;
                  crc_q   <= crc_rx;
                  state_q <= pgr_pkg::S_PARM;
               end
            end
            pgr_pkg::S_PARM: begin
               if (rx_take) begin
                  param_q    <= rx_byte_i;
                  result_q   <= (res_d == `PGR_RES_OK && opc_q == `PGR_OPC_READ &&
                                 len_d == `PGR_LEN_READ && rd_locked) ?
                                `PGR_RES_LOCKED : res_d;
                  len_q      <= len_d;
                  ht_req_q   <= ht_d;
                  crc_q      <= crc_rx;
                  tx_byte_q  <= ~crc_rx[7:0];
                  tx_valid_q <= 1'b1;
                  state_q    <= pgr_pkg::S_CRCL;
               end
            end
            pgr_pkg::S_CRCL: begin
               if (tx_take) begin
                  tx_byte_q <= ~crc_q[15:8];
                  state_q   <= pgr_pkg::S_CRCH;
               end
            end
            pgr_pkg::S_CRCH: begin
               if (tx_take) begin
                  tx_valid_q <= 1'b0;
                  state_q    <= pgr_pkg::S_REL;
               end
            end
            pgr_pkg::S_REL: begin
               if (rx_take) begin
                  cnt_q   <= ht_req_q ? 16'(READ_DELAY_CYC + HEALTH_DELAY_CYC - 1) :
                                        16'(READ_DELAY_CYC - 1);
                  state_q <= (rx_byte_i == `PGR_RELEASE) ? pgr_pkg::S_WAIT :
                                                           pgr_pkg::S_IDLE;
               end
            end
            pgr_pkg::S_WAIT: begin
               if (cnt_q == 16'h0000) begin
                  health_q   <= !ht_req_q ? `PGR_HT_NONE :
                                entropy_ok_i ? `PGR_HT_GOOD : `PGR_HT_BAD;
                  idx_q      <= 6'h00;
                  crc_q      <= 16'h0000;
                  tx_byte_q  <= `PGR_DUMMY;
                  tx_valid_q <= 1'b1;
                  state_q    <= pgr_pkg::S_RESP;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            pgr_pkg::S_RESP: begin
               if (tx_take) begin
                  if (idx_q == len_q + 6'h03) begin
                     tx_valid_q <= 1'b0;
                     state_q    <= pgr_pkg::S_IDLE;
                  end else begin
                     idx_q     <= nidx;
                     crc_q     <= crc_tx;
                     tx_byte_q <= next_byte;
                  end
               end
            end
            default: state_q <= pgr_pkg::S_IDLE;
         endcase
      end
   end

   // ---------------- register side ----------------
   logic        wr_go;
   logic [2:0]  w_page;
   logic        w_refuse;
   logic [7:0]  w_val;
   logic [2:0]  p_sel;

   // one wait cycle, then the access completes
   assign wr_go    = avs_write & ~avs_waitrequest;
   assign w_page   = maddr_q[7:5];
   assign p_sel    = avs_address[4:2];
   assign w_refuse = (w_page == `PGR_PAGES) ||
                     (prot_q[w_page][`PGR_BIT_WLOCK] &&
                      !(w_page == `PGR_CNT_PAGE && prot_q[3][`PGR_BIT_CNT]));
   assign w_val    = prot_q[w_page][`PGR_BIT_ONEWAY] ?
                     (mem_q[maddr_q] & avs_writedata[7:0]) : avs_writedata[7:0];

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(wait_q & (avs_read | avs_write));
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_go && avs_address == `PGR_OFS_MDATA && !w_refuse) begin
         mem_q[maddr_q] <= w_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         maddr_q    <= 8'h00;
         wrefused_q <= 1'b0;
      end else begin
         if (wr_go && avs_address == `PGR_OFS_MADDR) begin
            maddr_q <= avs_writedata[7:0];
         end else if (wr_go && avs_address == `PGR_OFS_MDATA) begin
            maddr_q <= maddr_q + 8'h01;
         end
         // a refusal in the clearing cycle stays set
         if (wr_go && avs_address == `PGR_OFS_MDATA && w_refuse) begin
            wrefused_q <= 1'b1;
         end else if (wr_go && avs_address == `PGR_OFS_STATUS && avs_writedata[0]) begin
            wrefused_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         for (int p = 0; p < 7; p++) begin
            prot_q[p] <= (p == 6) ? `PGR_PROT6_RST : `PGR_PROT_RST;
         end
      end else if (wr_go && avs_address[5] && p_sel != `PGR_PAGES &&
                   avs_address[1:0] == 2'h0) begin
         prot_q[p_sel] <= avs_writedata[4:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         disabled_q <= `PGR_CTRL_RST;
         maker_q    <= MAKER_CODE_RST;
      end else begin
         if (wr_go && avs_address == `PGR_OFS_CTRL) begin
            disabled_q <= avs_writedata[0];
         end
         if (wr_go && avs_address == `PGR_OFS_MAKER) begin
            maker_q <= avs_writedata[15:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && wait_q) begin
         if (avs_address[5] && p_sel != `PGR_PAGES && avs_address[1:0] == 2'h0) begin
            rdata_q <= {24'h00_0000, prot_rep(p_sel, prot_q[p_sel])};
         end else begin
            case (avs_address)
               `PGR_OFS_CTRL:   rdata_q <= {31'h0000_0000, disabled_q};
               `PGR_OFS_MAKER:  rdata_q <= {16'h0000, maker_q};
               `PGR_OFS_MADDR:  rdata_q <= {24'h00_0000, maddr_q};
               `PGR_OFS_MDATA:  rdata_q <= {24'h00_0000, mem_q[maddr_q]};
               `PGR_OFS_STATUS: rdata_q <= {16'h0000, result_q, 3'h0,
                                            state_q, wrefused_q};
               default:         rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         key_src_q  <= 1'b1;
         cnt_mode_q <= 1'b0;
      end else begin
         key_src_q  <= prot_q[6][`PGR_BIT_KEYSRC];
         cnt_mode_q <= prot_q[3][`PGR_BIT_CNT];
      end
   end

   assign tx_valid_o       = tx_valid_q;
   assign tx_byte_o        = tx_byte_q;
   assign key_source_puf_o = key_src_q;
   assign counter_mode_o   = cnt_mode_q;
   assign avs_readdata     = rdata_q;
   assign avs_waitrequest  = wait_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i || bus_reset_i);

   req_crc_a: assert property ((state_q == pgr_pkg::S_CRCL) |->
      tx_byte_o == ~crc_q[7:0]) else $error("request crc low byte wrong");
   read_len_a: assert property ((state_q == pgr_pkg::S_RESP && idx_q == 6'h01 &&
      opc_q == `PGR_OPC_READ && result_q == `PGR_RES_OK) |->
      tx_byte_o == 8'h21) else $error("page read length not 33");
   lock_fill_a: assert property ((state_q == pgr_pkg::S_RESP && result_q == `PGR_RES_LOCKED &&
      idx_q >= 6'h03 && idx_q <= 6'h22) |-> tx_byte_o == 8'hFF)
      else $error("locked page leaked data");
   stat_len_a: assert property ((state_q == pgr_pkg::S_RESP && idx_q == 6'h01 &&
      opc_q == `PGR_OPC_STATUS && result_q != `PGR_RES_DISABLE) |->
      tx_byte_o == 8'h0D) else $error("status length not 13");
   dis_len_a: assert property ((state_q == pgr_pkg::S_RESP &&
      result_q == `PGR_RES_DISABLE) |-> len_q == 6'h01)
      else $error("disabled answer longer than one byte");
   ht_none_a: assert property ((state_q == pgr_pkg::S_RESP && opc_q == `PGR_OPC_STATUS &&
      !ht_req_q && idx_q == 6'h0E && result_q != `PGR_RES_DISABLE) |->
      tx_byte_o == 8'hFF) else $error("untested health byte not FFh");
   wait_len_a: assert property ((state_q == pgr_pkg::S_WAIT &&
      $past(state_q) == pgr_pkg::S_REL) |->
      cnt_q == (ht_req_q ? 16'(READ_DELAY_CYC + HEALTH_DELAY_CYC - 1) :
                           16'(READ_DELAY_CYC - 1))) else $error("wrong delay");
   bad_parm_a: assert property ((state_q == pgr_pkg::S_PARM && rx_valid_i &&
      opc_q == `PGR_OPC_STATUS && !disabled_q && rx_byte_i[7:1] != 7'h00) |=>
      result_q == 8'h77 && !ht_req_q) else $error("bad status parameter accepted");
   key_src_a: assert property (##1 key_source_puf_o == $past(prot_q[6][4]))
      else $error("key source output stale");

endmodule : pgr_core

`default_nettype wire

// ### src/pgr_defs.svh
`ifndef PGR_DEFS_SVH
`define PGR_DEFS_SVH

// command bytes and result codes
`define PGR_CMD_START   8'h66
`define PGR_OPC_READ    8'h44
`define PGR_OPC_STATUS  8'hAA
`define PGR_RELEASE     8'hAA
`define PGR_DUMMY       8'hFF
`define PGR_RES_OK      8'hAA
`define PGR_RES_LOCKED  8'h55
`define PGR_RES_BADPARM 8'h77
`define PGR_RES_DISABLE 8'h88
`define PGR_HT_NONE     8'hFF
`define PGR_HT_GOOD     8'hAA
`define PGR_HT_BAD      8'hDD
`define PGR_FILL_BYTE   8'hFF

// frame lengths
`define PGR_LEN_REQ     8'h02
`define PGR_LEN_READ    6'h21
`define PGR_LEN_STATUS  6'h0D
`define PGR_LEN_ERR     6'h01

// memory geometry
`define PGR_PAGES       3'h7
`define PGR_KEY_PAGE    3'h6
`define PGR_CNT_PAGE    3'h3
`define PGR_PROT_BYTES  6'h07

// protection byte fields
`define PGR_BIT_RLOCK   0
`define PGR_BIT_WLOCK   1
`define PGR_BIT_ONEWAY  2
`define PGR_BIT_CNT     3
`define PGR_BIT_KEYSRC  4
`define PGR_PROT_RST    5'h00
`define PGR_PROT6_RST   5'h11

// crc-16, reflected form of x16+x15+x2+1
`define PGR_CRC_POLY    16'hA001

// register byte offsets
`define PGR_OFS_CTRL    6'h00
`define PGR_OFS_MAKER   6'h04
`define PGR_OFS_MADDR   6'h08
`define PGR_OFS_MDATA   6'h0C
`define PGR_OFS_STATUS  6'h14
`define PGR_OFS_PROT0   6'h20
`define PGR_CTRL_RST    1'h0

// timing
`define PGR_CLK_MHZ          200
`define PGR_READ_DELAY_NS    2000
`define PGR_HEALTH_DELAY_NS  20000
`define PGR_READ_DELAY_CYC   ((`PGR_READ_DELAY_NS * `PGR_CLK_MHZ + 999) / 1000)
`define PGR_HEALTH_DELAY_CYC ((`PGR_HEALTH_DELAY_NS * `PGR_CLK_MHZ + 999) / 1000)

`endif

// ### src/pgr_pkg.sv
`default_nettype none
package pgr_pkg;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_LEN  = 4'h1,
      S_OPC  = 4'h2,
      S_PARM = 4'h3,
      S_CRCL = 4'h4,
      S_CRCH = 4'h5,
      S_REL  = 4'h6,
      S_WAIT = 4'h7,
      S_RESP = 4'h8
   } pgr_state_t;
endpackage : pgr_pkg
`default_nettype wire
